// ---- hw/dma_step_defines.vh ----
// Constants shared by the DMA block address stepper design files
`ifndef DMA_STEP_DEFINES_VH
`define DMA_STEP_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_BEAT_COUNT 8'h04
`define OFS_SRC_START  8'h08
`define OFS_DST_START  8'h0c
`define OFS_COMMAND    8'h10
`define OFS_STATUS     8'h14
`define OFS_SRC_END    8'h18
`define OFS_DST_END    8'h1c
`define OFS_REMAINING  8'h20

// ==========================================================
// Block transfer control fields
`define CTRL_SRC_INC_BIT  0
`define CTRL_DST_INC_BIT  1
`define CTRL_STEP_SEL_BIT 2
`define CTRL_BW_LSB       4
`define CTRL_BW_MSB       5
`define CTRL_STEP_LSB     8
`define CTRL_STEP_MSB     10
`define CTRL_WIDTH        11
`define CTRL_RESET        11'h000

// ==========================================================
// Command and status fields
`define CMD_START_BIT  0
`define CMD_ABORT_BIT  1
`define STAT_BUSY_BIT  0
`define STAT_DONE_BIT  1

// ==========================================================
// Widths and reset values
`define ADDR_W        32
`define COUNT_W       16
`define BW_W          2
`define STEP_W        3
`define ADDR_RESET    32'h0000_0000
`define COUNT_RESET   16'h0000
`define COUNT_ONE     16'h0001
`define PRODUCT_W     18
`define SIDE_COUNT    2
`define SIDE_SRC      0
`define SIDE_DST      1

// ==========================================================
// Sequencer states
`define ST_IDLE 1'b0
`define ST_RUN  1'b1

`endif

// ---- hw/addr_end_calc.v ----
// End address calculator for one side of a block transfer
`timescale 1ns/1ps
`default_nettype none
`include "dma_step_defines.vh"

module addr_end_calc (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [`ADDR_W-1:0] start_addr_i,
    input wire [`COUNT_W-1:0] beat_count_i,
    input wire [`BW_W-1:0] beat_width_i,
    input wire [`STEP_W-1:0] step_size_i,
    input wire inc_en_i,
    input wire use_step_i,
    output reg [`ADDR_W-1:0] end_addr_o
);

    // ==========================================================
    // Formula: start + count * (width + 1), times 2^step only if use_step_i; start alone if inc_en_i is 0
    wire [`BW_W:0] beat_bytes;
    wire [`PRODUCT_W-1:0] product;
    wire [`ADDR_W-1:0] product_ext;
    wire [`ADDR_W-1:0] scaled;
    reg [`ADDR_W-1:0] end_addr_next;

    assign beat_bytes = {1'b0, beat_width_i} + {{`BW_W{1'b0}}, 1'b1};
    assign product = beat_count_i * beat_bytes;
    assign product_ext = {{(`ADDR_W-`PRODUCT_W){1'b0}}, product};
    assign scaled = use_step_i ? (product_ext << step_size_i) : product_ext;

    always @* begin
        end_addr_next = start_addr_i;
        if (inc_en_i) begin
            end_addr_next = start_addr_i + scaled;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            end_addr_o <= `ADDR_RESET;
        end else begin
            end_addr_o <= end_addr_next;
        end
    end

endmodule
`default_nettype wire

// ---- hw/addr_beat_stepper.v ----
// Per-beat address register for one side of a block transfer
`timescale 1ns/1ps
`default_nettype none
`include "dma_step_defines.vh"

module addr_beat_stepper (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire load_i,
    input wire advance_i,
    input wire [`ADDR_W-1:0] start_addr_i,
    input wire [`BW_W-1:0] beat_width_i,
    input wire [`STEP_W-1:0] step_size_i,
    input wire inc_en_i,
    input wire use_step_i,
    output reg [`ADDR_W-1:0] addr_o
);

    // ==========================================================
    // Step is frozen at load so config writes cannot bend a running block
    reg [`ADDR_W-1:0] step_reg;
    reg [`ADDR_W-1:0] step_next;
    wire [`ADDR_W-1:0] beat_bytes;

    assign beat_bytes = {{(`ADDR_W-`BW_W){1'b0}}, beat_width_i} + `ADDR_W'h1;

    always @* begin
        step_next = beat_bytes;
        if (use_step_i) begin
            step_next = beat_bytes << step_size_i;
        end
        if (!inc_en_i) begin
            step_next = `ADDR_RESET;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_o <= `ADDR_RESET;
            step_reg <= `ADDR_RESET;
        end else if (load_i) begin
            addr_o <= start_addr_i;
            step_reg <= step_next;
        end else if (advance_i) begin
            addr_o <= addr_o + step_reg;
        end
    end

endmodule
`default_nettype wire

// ---- hw/dma_block_address_stepper.v ----
// Top of the DMA block address stepper: registers, sequencer, two sides
// Summary of operation
// - Source address advances per beat only when source increment enable is 1.
// - Step select 1 gives source the programmable step; 0 gives one beat.
// - Source end address = start + count * (width + 1), scaled by 2^step if select is 1; start alone if source increment enable is 0.
// - Destination address advances per beat only when destination increment enable is 1.
// - Step select 0 gives destination the programmable step; 1 gives one beat.
// - Step size is the log2 of beats per increment; width field plus one gives bytes per beat.
// - Beat count term is the initial count; start address is the first beat's.
`timescale 1ns/1ps
`default_nettype none
`include "dma_step_defines.vh"

module dma_block_address_stepper (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire beat_ack_i,
    output reg beat_valid_o,
    output reg beat_last_o,
    output wire [`ADDR_W-1:0] beat_src_addr_o,
    output wire [`ADDR_W-1:0] beat_dst_addr_o,
    output reg busy_o,
    output reg done_o
);

    // ==========================================================
    // Software registers
    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [`COUNT_W-1:0] beat_count_reg;
    reg [`ADDR_W-1:0] src_start_reg;
    reg [`ADDR_W-1:0] dst_start_reg;
    reg [`COUNT_W-1:0] remaining_reg;
    reg [`COUNT_W-1:0] remaining_next;
    reg state_reg;
    reg state_next;
    reg done_next;
    reg valid_next;
    reg last_next;
    reg [31:0] rdata_next;

    wire src_inc;
    wire dst_inc;
    wire step_sel;
    wire [`BW_W-1:0] beat_width;
    wire [`STEP_W-1:0] step_size;

    assign src_inc = ctrl_reg[`CTRL_SRC_INC_BIT];
    assign dst_inc = ctrl_reg[`CTRL_DST_INC_BIT];
    assign step_sel = ctrl_reg[`CTRL_STEP_SEL_BIT];
    assign beat_width = ctrl_reg[`CTRL_BW_MSB:`CTRL_BW_LSB];
    assign step_size = ctrl_reg[`CTRL_STEP_MSB:`CTRL_STEP_LSB];

    wire wr_ctrl;
    wire wr_count;
    wire wr_src;
    wire wr_dst;
    wire wr_cmd;
    wire wr_status;
    wire start_req;
    wire abort_req;
    wire done_clear;
    wire beat_taken;
    wire load_sides;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == `OFS_CTRL);
    assign wr_count = reg_wr_i && (reg_addr_i == `OFS_BEAT_COUNT);
    assign wr_src = reg_wr_i && (reg_addr_i == `OFS_SRC_START);
    assign wr_dst = reg_wr_i && (reg_addr_i == `OFS_DST_START);
    assign wr_cmd = reg_wr_i && (reg_addr_i == `OFS_COMMAND);
    assign wr_status = reg_wr_i && (reg_addr_i == `OFS_STATUS);
    assign start_req = wr_cmd && reg_wdata_i[`CMD_START_BIT];
    assign abort_req = wr_cmd && reg_wdata_i[`CMD_ABORT_BIT];
    assign done_clear = wr_status && reg_wdata_i[`STAT_DONE_BIT];
    assign beat_taken = beat_valid_o && beat_ack_i;
    // Start while a block runs is ignored
    assign load_sides = start_req && (state_reg == `ST_IDLE);

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= `CTRL_RESET;
            beat_count_reg <= `COUNT_RESET;
            src_start_reg <= `ADDR_RESET;
            dst_start_reg <= `ADDR_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata_i[`CTRL_WIDTH-1:0];
            end
            if (wr_count) begin
                beat_count_reg <= reg_wdata_i[`COUNT_W-1:0];
            end
            if (wr_src) begin
                src_start_reg <= reg_wdata_i;
            end
            if (wr_dst) begin
                dst_start_reg <= reg_wdata_i;
            end
        end
    end

    // ==========================================================
    // Per-side address logic
    wire [`ADDR_W-1:0] side_start [0:`SIDE_COUNT-1];
    wire side_inc [0:`SIDE_COUNT-1];
    wire side_use_step [0:`SIDE_COUNT-1];
    wire [`ADDR_W-1:0] side_end [0:`SIDE_COUNT-1];
    wire [`ADDR_W-1:0] side_addr [0:`SIDE_COUNT-1];

    assign side_start[`SIDE_SRC] = src_start_reg;
    assign side_start[`SIDE_DST] = dst_start_reg;
    assign side_inc[`SIDE_SRC] = src_inc;
    assign side_inc[`SIDE_DST] = dst_inc;
    // Step select hands the programmable step to exactly one side
    assign side_use_step[`SIDE_SRC] = step_sel;
    assign side_use_step[`SIDE_DST] = ~step_sel;

    genvar side;
    generate
        for (side = 0; side < `SIDE_COUNT; side = side + 1) begin : g_side
            addr_end_calc u_end (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .start_addr_i(side_start[side]),
                .beat_count_i(beat_count_reg),
                .beat_width_i(beat_width),
                .step_size_i(step_size),
                .inc_en_i(side_inc[side]),
                .use_step_i(side_use_step[side]),
                .end_addr_o(side_end[side])
            );

            addr_beat_stepper u_step (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .load_i(load_sides),
                .advance_i(beat_taken),
                .start_addr_i(side_start[side]),
                .beat_width_i(beat_width),
                .step_size_i(step_size),
                .inc_en_i(side_inc[side]),
                .use_step_i(side_use_step[side]),
                .addr_o(side_addr[side])
            );
        end
    endgenerate

    // Straight from the stepper flip-flops
    assign beat_src_addr_o = side_addr[`SIDE_SRC];
    assign beat_dst_addr_o = side_addr[`SIDE_DST];

    // ==========================================================
    // Beat sequencer
    always @* begin
        state_next = state_reg;
        remaining_next = remaining_reg;
        valid_next = beat_valid_o;
        last_next = beat_last_o;
        done_next = done_o;
        if (done_clear) begin
            done_next = 1'b0;
        end
        case (state_reg)
            `ST_IDLE: begin
                if (start_req) begin
                    remaining_next = beat_count_reg;
                    if (beat_count_reg == `COUNT_RESET) begin
                        // Empty block finishes at once
                        done_next = 1'b1;
                    end else begin
                        state_next = `ST_RUN;
                        valid_next = 1'b1;
                        last_next = (beat_count_reg == `COUNT_ONE);
                    end
                end
            end
            `ST_RUN: begin
                if (abort_req) begin
                    state_next = `ST_IDLE;
                    valid_next = 1'b0;
                    last_next = 1'b0;
                    remaining_next = `COUNT_RESET;
                end else if (beat_taken) begin
                    remaining_next = remaining_reg - `COUNT_ONE;
                    last_next = (remaining_reg == (`COUNT_ONE + `COUNT_ONE));
                    if (remaining_reg == `COUNT_ONE) begin
                        state_next = `ST_IDLE;
                        valid_next = 1'b0;
                        last_next = 1'b0;
                        // Set beats a same-cycle clear
                        done_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = `ST_IDLE;
                valid_next = 1'b0;
                last_next = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= `ST_IDLE;
            remaining_reg <= `COUNT_RESET;
            beat_valid_o <= 1'b0;
            beat_last_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            remaining_reg <= remaining_next;
            beat_valid_o <= valid_next;
            beat_last_o <= last_next;
            busy_o <= (state_next == `ST_RUN);
            done_o <= done_next;
        end
    end

    // ==========================================================
    // Read port, data stand one cycle after the strobe only
    always @* begin
        rdata_next = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `OFS_CTRL: rdata_next = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg};
                `OFS_BEAT_COUNT: rdata_next = {{(32-`COUNT_W){1'b0}}, beat_count_reg};
                `OFS_SRC_START: rdata_next = src_start_reg;
                `OFS_DST_START: rdata_next = dst_start_reg;
                `OFS_STATUS: begin
                    rdata_next[`STAT_BUSY_BIT] = busy_o;
                    rdata_next[`STAT_DONE_BIT] = done_o;
                end
                `OFS_SRC_END: rdata_next = side_end[`SIDE_SRC];
                `OFS_DST_END: rdata_next = side_end[`SIDE_DST];
                `OFS_REMAINING: rdata_next = {{(32-`COUNT_W){1'b0}}, remaining_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

endmodule
`default_nettype wire

// ---- verification/stepper_assertions.sv ----
// Port-level checker for the DMA block address stepper
`timescale 1ns/1ps
`default_nettype none
`include "dma_step_defines.vh"
module stepper_checker (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic beat_ack_i,
    input wire logic beat_valid_o,
    input wire logic beat_last_o,
    input wire logic [`ADDR_W-1:0] beat_src_addr_o,
    input wire logic [`ADDR_W-1:0] beat_dst_addr_o,
    input wire logic busy_o,
    input wire logic done_o
);
    // ==========================================================
    // Shadow of the configuration, taken from bus writes
    logic [10:0] ctrl_reg;
    logic [15:0] count_reg;
    logic [31:0] src_reg;
    logic [31:0] dst_reg;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= 11'h000;
            count_reg <= 16'h0000;
            src_reg <= 32'h0;
            dst_reg <= 32'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `OFS_CTRL: ctrl_reg <= reg_wdata_i[10:0];
                `OFS_BEAT_COUNT: count_reg <= reg_wdata_i[15:0];
                `OFS_SRC_START: src_reg <= reg_wdata_i;
                `OFS_DST_START: dst_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end
    // Shadow is only valid while the bench leaves config alone mid-run
    wire logic [31:0] unit_w = {30'h0, ctrl_reg[5:4]} + 32'h1;
    wire logic [31:0] scaled_w = unit_w << ctrl_reg[10:8];
    wire logic [31:0] src_step = ctrl_reg[0] ? (ctrl_reg[2] ? scaled_w : unit_w) : 32'h0;
    wire logic [31:0] dst_step = ctrl_reg[1] ? (ctrl_reg[2] ? unit_w : scaled_w) : 32'h0;
    // Abort may withdraw an offered beat at any edge
    wire logic abort_w = reg_wr_i && reg_addr_i == `OFS_COMMAND && reg_wdata_i[1];
    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence take_s;
        beat_valid_o && beat_ack_i;
    endsequence
    sequence start_s;
        reg_wr_i && reg_addr_i == `OFS_COMMAND && reg_wdata_i[0] && !busy_o;
    endsequence
    src_step_a: assert property (take_s ##0 !beat_last_o |=>
        beat_src_addr_o == $past(beat_src_addr_o + src_step))
        else $error("Source address stepped wrongly");
    dst_step_a: assert property (take_s ##0 !beat_last_o |=>
        beat_dst_addr_o == $past(beat_dst_addr_o + dst_step))
        else $error("Destination address stepped wrongly");
    start_pair_a: assert property (start_s ##0 count_reg != 16'h0 |=>
        beat_valid_o && beat_src_addr_o == src_reg && beat_dst_addr_o == dst_reg)
        else $error("First beat not at start addresses");
    zero_count_a: assert property (start_s ##0 count_reg == 16'h0 |=>
        done_o && !beat_valid_o && !busy_o)
        else $error("Empty block did not finish at once");
    hold_offer_a: assert property (beat_valid_o && !beat_ack_i && !abort_w |=>
        beat_valid_o && $stable(beat_src_addr_o) && $stable(beat_dst_addr_o) &&
        $stable(beat_last_o))
        else $error("Offered beat changed before it was taken");
    block_end_a: assert property (take_s ##0 beat_last_o && !abort_w |=>
        !beat_valid_o && !busy_o && done_o)
        else $error("Block did not end after the last beat");
    abort_stop_a: assert property (busy_o && abort_w |=>
        !beat_valid_o && !busy_o && !beat_last_o && $stable(done_o))
        else $error("Abort did not stop the block");
    last_live_a: assert property (beat_last_o |-> beat_valid_o && busy_o)
        else $error("Last flag without a live beat");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("Read data outside the read answer cycle");
    status_read_a: assert property (reg_rd_i && reg_addr_i == `OFS_STATUS |=>
        reg_rdata_o == {30'h0, $past(done_o), $past(busy_o)})
        else $error("Status read does not match busy and done");
endmodule
bind dma_block_address_stepper stepper_checker checker_i (.sys_clk_i, .arst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .beat_ack_i,
    .beat_valid_o, .beat_last_o, .beat_src_addr_o, .beat_dst_addr_o, .busy_o, .done_o);
`default_nettype wire

// ---- verification/beat_sink.sv ----
// Memory-side beat sink with a programmable acceptance delay
`timescale 1ns/1ps
`default_nettype none
module beat_sink (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic beat_valid_i,
    input wire logic [3:0] wait_i,
    output logic beat_ack_o
);
    logic [3:0] wait_reg;
    // Zero delay keeps ack up, so beats go back to back
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            beat_ack_o <= 1'b0;
            wait_reg <= 4'h0;
        end else if (wait_i == 4'h0) begin
            beat_ack_o <= 1'b1;
        end else if (beat_valid_i && !beat_ack_o) begin
            wait_reg <= wait_reg + 4'h1;
            beat_ack_o <= (wait_reg + 4'h1 >= wait_i);
        end else begin
            beat_ack_o <= 1'b0;
            wait_reg <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// ---- verification/dma_block_address_stepper_test.sv ----
// Testbench for the DMA block address stepper
`timescale 1ns/1ps
`default_nettype none
`include "dma_step_defines.vh"
module dma_block_address_stepper_test;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [3:0] wait_reg = 4'h0;
    logic [31:0] reg_rdata_o, beat_src_addr_o, beat_dst_addr_o;
    logic beat_ack_i, beat_valid_o, beat_last_o, busy_o, done_o;
    int miscompares = 0;
    int checks = 0;
    dma_block_address_stepper dut (.sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .beat_ack_i, .beat_valid_o, .beat_last_o,
        .beat_src_addr_o, .beat_dst_addr_o, .busy_o, .done_o);
    beat_sink sink (.sys_clk_i, .arst_n_i, .beat_valid_i(beat_valid_o), .wait_i(wait_reg),
        .beat_ack_o(beat_ack_i));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // Bus and compare helpers
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    // ==========================================================
    // Scenarios
    task run_block(input logic [10:0] c, input logic [15:0] n, input logic [3:0] w);
        logic [31:0] s, d, unit, ss, ds, v;
        int k;
        s = 32'h2000_0100;
        d = 32'h3000_0040;
        unit = {30'h0, c[5:4]} + 32'h1;
        ss = c[0] ? (c[2] ? unit << c[10:8] : unit) : 32'h0;
        ds = c[1] ? (c[2] ? unit : unit << c[10:8]) : 32'h0;
        wait_reg <= w;
        wr(`OFS_CTRL, {21'h0, c});
        wr(`OFS_BEAT_COUNT, {16'h0, n});
        wr(`OFS_SRC_START, s);
        wr(`OFS_DST_START, d);
        wr(`OFS_COMMAND, 32'h1);
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge sys_clk_i);
            while (!(beat_valid_o === 1'b1 && beat_ack_i === 1'b1) && k < 100) begin
                @(negedge sys_clk_i);
                k++;
            end
            chk({31'h0, k < 100}, 32'h1, "beat offered in time");
            chk({31'h0, busy_o}, 32'h1, "busy during block");
            chk(beat_src_addr_o, s + i * ss, "source address");
            chk(beat_dst_addr_o, d + i * ds, "destination address");
            chk({31'h0, beat_last_o}, {31'h0, i == n - 1}, "last flag");
        end
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk({30'h0, done_o, busy_o}, 32'h2, "done pin after block");
        rd(`OFS_STATUS, v);
        chk(v, 32'h2, "done after block");
        wr(`OFS_STATUS, 32'h2);
        rd(`OFS_STATUS, v);
        chk(v, 32'h0, "done cleared");
        rd(`OFS_SRC_END, v);
        chk(v, s + n * ss, "source end");
        rd(`OFS_DST_END, v);
        chk(v, d + n * ds, "destination end");
        rd(`OFS_REMAINING, v);
        chk(v, 32'h0, "beats left");
        $display("Block ctrl %h count %0d finished", c, n);
    endtask
    task abort_block;
        logic [31:0] v;
        // Slow sink keeps the first beat on offer through the abort
        wait_reg <= 4'hf;
        wr(`OFS_CTRL, 32'h0000_0001);
        wr(`OFS_BEAT_COUNT, 32'h0000_0008);
        wr(`OFS_SRC_START, 32'h4000_0000);
        wr(`OFS_COMMAND, 32'h1);
        wr(`OFS_COMMAND, 32'h1);
        rd(`OFS_REMAINING, v);
        chk(v, 32'h8, "start while busy ignored");
        chk({31'h0, busy_o}, 32'h1, "busy before abort");
        wr(`OFS_COMMAND, 32'h2);
        #1;
        chk({30'h0, beat_valid_o, busy_o}, 32'h0, "beat withdrawn by abort");
        chk(beat_src_addr_o, 32'h4000_0000, "no beat taken");
        rd(`OFS_STATUS, v);
        chk(v, 32'h0, "abort sets no done");
        rd(`OFS_REMAINING, v);
        chk(v, 32'h0, "abort clears beats left");
        wr(`OFS_COMMAND, 32'h2);
        rd(`OFS_STATUS, v);
        chk(v, 32'h0, "abort while idle ignored");
        $display("Abort scenario finished");
    endtask
    task reg_basics;
        logic [31:0] v;
        rd(`OFS_CTRL, v);
        chk(v, 32'h0, "control reset value");
        rd(`OFS_STATUS, v);
        chk(v, 32'h0, "status reset value");
        rd(8'h3c, v);
        chk(v, 32'h0, "unmapped read");
        wr(`OFS_CTRL, 32'hffff_ffff);
        rd(`OFS_CTRL, v);
        chk(v, 32'h0000_07ff, "control fields");
        rd(`OFS_COMMAND, v);
        chk(v, 32'h0, "command reads zero");
        $display("Register basics finished");
    endtask
    task src_one_beat;
        run_block(11'h001, 16'h0002, 4'h0);
    endtask
    task src_stepped;
        run_block(11'h117, 16'h0004, 4'h2);
    endtask
    task dst_stepped;
        run_block(11'h233, 16'h0003, 4'h0);
    endtask
    task largest_step;
        run_block(11'h735, 16'h0002, 4'h3);
    endtask
    task no_increment;
        run_block(11'h724, 16'h0003, 4'h1);
    endtask
    task empty_block;
        run_block(11'h003, 16'h0000, 4'h0);
    endtask
    task summarize;
        $display("Checks %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        reg_basics();
        src_one_beat();
        src_stepped();
        dst_stepped();
        largest_step();
        no_increment();
        abort_block();
        empty_block();
        summarize();
    end
    initial begin
        #50000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
